//--- core/sdc_seq.sv
// conversion sequencer for a delta-sigma converter
// assumes modulator bitstream synchronous to clk_sys, reader pulses rd
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defs.svh"
module sdc_seq
  import sdc_pkg::*;
#(
  parameter int W = `SDC_RES_HI,
  parameter int OSR_HI = `SDC_OSR_HI,
  parameter int OSR_LO = `SDC_OSR_LO
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic [1:0] mode,
  input wire logic lo_res,
  input wire logic start_bit,
  input wire logic trig,
  input wire logic stop,
  input wire logic in_sel_chg,
  // modulator
  input wire logic mod_bit,
  // result
  input wire logic rd,
  output logic [W-1:0] result_ff,
  output logic done_ff,
  output logic status_ff,
  output logic valid_ff,
  output logic busy_ff
);
  sdc_state_t st_ff, nxt_st;
  logic [15:0] cyc_ff, nxt_cyc;
  logic [2:0] cnv_ff, nxt_cnv;
  logic [2:0] vcnt_ff, nxt_vcnt;
  logic [W-1:0] nxt_result;
  logic nxt_done, nxt_valid, nxt_busy, nxt_status;
  logic pend_ff, nxt_pend;
  logic conv_end, dclr, go;
  logic [W-1:0] dsum;
  logic [15:0] osr;

  // conversion length trades resolution for rate
  assign osr = lo_res ? 16'(OSR_LO) : 16'(OSR_HI);
  assign conv_end = (st_ff == SDC_ST_PRIME || st_ff == SDC_ST_RUN) &&
                    (cyc_ff == osr - 16'h0001);
  assign go = start_bit | trig;

  sdc_decim #(.W(W)) u_decim (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(dclr),
    .bit_in(mod_bit),
    .conv_end(conv_end),
    .sum_ff(dsum)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_cyc = cyc_ff;
    nxt_cnv = cnv_ff;
    nxt_result = result_ff;
    nxt_done = done_ff;
    nxt_status = status_ff;
    nxt_valid = valid_ff;
    nxt_vcnt = vcnt_ff;
    dclr = 1'b0;
    if (st_ff == SDC_ST_PRIME || st_ff == SDC_ST_RUN)
      nxt_cyc = conv_end ? 16'h0000 : cyc_ff + 16'h0001;
    if (in_sel_chg) begin
      nxt_vcnt = 3'h0;
      nxt_valid = 1'b0;
    end else if (conv_end && vcnt_ff < 3'(`SDC_TAPS)) begin
      nxt_vcnt = vcnt_ff + 3'h1;
    end
    // read clears; a new result in the same cycle wins below
    if (rd) begin
      nxt_done = 1'b0;
      nxt_status = 1'b0;
    end
    // result posted once the decimator sum is registered
    nxt_pend = (st_ff == SDC_ST_RUN) && conv_end;
    if (pend_ff) begin
      nxt_result = dsum;
      nxt_done = 1'b1;
      nxt_status = 1'b1;
      nxt_valid = (nxt_vcnt >= 3'(`SDC_TAPS));
    end
    unique case (st_ff)
      SDC_ST_IDLE: begin
        if (go) begin
          nxt_st = SDC_ST_PRIME;
          nxt_cyc = 16'h0000;
          nxt_cnv = 3'h0;
          dclr = 1'b1;
        end
      end
      SDC_ST_PRIME: begin
        if (conv_end) begin
          nxt_cnv = cnv_ff + 3'h1;
          if (cnv_ff == 3'(`SDC_PRIME_CNT - 1)) nxt_st = SDC_ST_RUN;
        end
      end
      SDC_ST_RUN: begin
        if (conv_end) begin
          unique case (mode)
            SDC_MODE_CONT: nxt_st = stop ? SDC_ST_IDLE : SDC_ST_RUN;
            SDC_MODE_MULTI, SDC_MODE_TURBO: begin
              nxt_st = stop ? SDC_ST_IDLE : SDC_ST_PRIME;
              nxt_cnv = 3'h0;
              dclr = ~stop;
            end
            default: nxt_st = SDC_ST_HOLD;
          endcase
        end
      end
      SDC_ST_HOLD: begin
        if (rd) nxt_st = SDC_ST_IDLE;
      end
    endcase
    nxt_busy = (nxt_st != SDC_ST_IDLE);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= SDC_ST_IDLE;
      cyc_ff <= 16'h0000;
      cnv_ff <= 3'h0;
      vcnt_ff <= 3'h0;
      result_ff <= '0;
      done_ff <= 1'b0;
      status_ff <= 1'b0;
      valid_ff <= 1'b0;
      busy_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cyc_ff <= nxt_cyc;
      cnv_ff <= nxt_cnv;
      vcnt_ff <= nxt_vcnt;
      result_ff <= nxt_result;
      done_ff <= nxt_done;
      status_ff <= nxt_status;
      valid_ff <= nxt_valid;
      busy_ff <= nxt_busy;
      pend_ff <= nxt_pend;
    end
  end

  done_hold_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    done_ff && !rd |=> done_ff)
    else $error("done dropped without read");
  done_rise_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    st_ff == SDC_ST_RUN && conv_end |=> ##1 (done_ff && status_ff))
    else $error("done not set at result");
  busy_ign_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    st_ff == SDC_ST_PRIME && go
    |=> cyc_ff != 16'h0000 || cnv_ff == $past(cnv_ff) + 3'h1)
    else $error("start restarted a running sequence");
  hold_stay_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    st_ff == SDC_ST_HOLD && !rd |=> st_ff == SDC_ST_HOLD)
    else $error("sequence left hold early");
  prime_len_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    st_ff == SDC_ST_IDLE && go
    |=> st_ff == SDC_ST_PRIME && cnv_ff == 3'h0 && cyc_ff == 16'h0000)
    else $error("no priming after start");
  prime_end_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    st_ff == SDC_ST_PRIME && conv_end && cnv_ff == 3'(`SDC_PRIME_CNT - 1)
    |=> st_ff == SDC_ST_RUN)
    else $error("priming length wrong");
  stby_ret_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    st_ff == SDC_ST_HOLD && rd |=> st_ff == SDC_ST_IDLE)
    else $error("no standby after read");
  cont_run_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    st_ff == SDC_ST_RUN && conv_end && mode == SDC_MODE_CONT && !stop
    |=> st_ff == SDC_ST_RUN)
    else $error("continuous re-primed");
  multi_re_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    st_ff == SDC_ST_RUN && conv_end && mode[1] && !stop
    |=> st_ff == SDC_ST_PRIME && cnv_ff == 3'h0)
    else $error("multi did not re-prime");
  chg_inv_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    in_sel_chg |=> !valid_ff)
    else $error("valid after input change");
endmodule : sdc_seq
`default_nettype wire

//--- inc/sdc_defs.svh
// constants for the delta-sigma conversion sequencer
// assumes a 20 MHz system clock
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH
`define SDC_CLK_HZ 20000000
`define SDC_RATE_HI_SPS 192000
`define SDC_RATE_LO_SPS 384000
`define SDC_RES_HI 12
`define SDC_RES_LO 8
`define SDC_PRIME_CNT 3
`define SDC_TAPS 4
`define SDC_OSR_HI (`SDC_CLK_HZ / `SDC_RATE_HI_SPS)
`define SDC_OSR_LO (`SDC_CLK_HZ / `SDC_RATE_LO_SPS)
`endif

//--- inc/sdc_pkg.sv
// types for the delta-sigma conversion sequencer
// no assumptions
package sdc_pkg;
  typedef enum logic [1:0] {
    SDC_MODE_SINGLE = 2'h0,
    SDC_MODE_CONT = 2'h1,
    SDC_MODE_MULTI = 2'h2,
    SDC_MODE_TURBO = 2'h3
  } sdc_mode_t;
  typedef enum logic [1:0] {
    SDC_ST_IDLE = 2'h0,
    SDC_ST_PRIME = 2'h1,
    SDC_ST_RUN = 2'h3,
    SDC_ST_HOLD = 2'h2
  } sdc_state_t;
endpackage : sdc_pkg

//--- core/sdc_decim.sv
// decimator: counts ones per conversion, sums four latest conversions
// assumes bitstream one bit per clock, clear restarts the pipeline
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defs.svh"
module sdc_decim
  import sdc_pkg::*;
#(
  parameter int W = 12
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clr,
  input wire logic bit_in,
  input wire logic conv_end,
  output logic [W-1:0] sum_ff
);
  logic [W-1:0] acc_ff;
  logic [W-1:0] nxt_acc;
  logic [W-1:0] tap_ff [`SDC_TAPS];
  logic [W-1:0] nxt_tap [`SDC_TAPS];
  logic [W-1:0] nxt_sum;

  always_comb begin
    nxt_acc = acc_ff + W'(bit_in);
    nxt_sum = sum_ff;
    if (conv_end) begin
      nxt_acc = '0;
      nxt_sum = W'(acc_ff + W'(bit_in) + tap_ff[0] + tap_ff[1] + tap_ff[2]);
    end
    // sum survives clr so a result ending in a restart is kept
    if (clr) nxt_acc = '0;
  end

  genvar g;
  generate
    for (g = 0; g < `SDC_TAPS; g++) begin : g_tap
      logic [W-1:0] shift_in;
      if (g == 0) begin : g_head
        assign shift_in = W'(acc_ff + W'(bit_in));
      end else begin : g_next
        assign shift_in = tap_ff[g-1];
      end
      always_comb begin
        nxt_tap[g] = tap_ff[g];
        if (conv_end) nxt_tap[g] = shift_in;
        if (clr) nxt_tap[g] = '0;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_ff <= '0;
      sum_ff <= '0;
      for (int i = 0; i < `SDC_TAPS; i++) tap_ff[i] <= '0;
    end else begin
      acc_ff <= nxt_acc;
      sum_ff <= nxt_sum;
      for (int i = 0; i < `SDC_TAPS; i++) tap_ff[i] <= nxt_tap[i];
    end
  end
endmodule : sdc_decim
`default_nettype wire

//--- tb/sdc_reader.sv
// partner model: reader that fetches a result while done is high
// assumes its inputs settle before the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module sdc_reader (
  // clock
  input wire logic clk_sys,
  // control
  input wire logic en,
  input wire logic [3:0] lat,
  // result side
  input wire logic done_ff,
  output logic rd
);
  logic [3:0] cnt = 4'h0;
  always @(negedge clk_sys) begin
    rd <= 1'b0;
    if (en && done_ff === 1'b1 && !rd) begin
      if (cnt >= lat) begin
        rd <= 1'b1;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : sdc_reader
`default_nettype wire

//--- tb/tb_sigma_delta_adc_conversion_sequencer.sv
// testbench for the conversion sequencer with its reader model
// assumes shortened conversions: 4 clocks long, 2 with lo_res
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module tb_sigma_delta_adc_conversion_sequencer;
  logic clk_sys = 1'b0, rst = 1'b1, lo_res = 1'b0, start_bit = 1'b0;
  logic trig = 1'b0, stop = 1'b0, in_sel_chg = 1'b0, mod_bit = 1'b1;
  logic rd, done_ff, status_ff, valid_ff, busy_ff;
  logic [1:0] mode = 2'h0;
  logic [3:0] lat = 4'h0;
  logic [11:0] result_ff;
  int error_cnt = 0, n_compared = 0, n;
  always #25 clk_sys = ~clk_sys;
  sdc_seq #(.W(12), .OSR_HI(4), .OSR_LO(2)) u_dut (.clk_sys(clk_sys),
    .rst(rst), .mode(mode), .lo_res(lo_res), .start_bit(start_bit),
    .trig(trig), .stop(stop), .in_sel_chg(in_sel_chg), .mod_bit(mod_bit),
    .rd(rd), .result_ff(result_ff), .done_ff(done_ff),
    .status_ff(status_ff), .valid_ff(valid_ff), .busy_ff(busy_ff));
  sdc_reader u_rdr (.clk_sys(clk_sys), .en(1'b1), .lat(lat),
    .done_ff(done_ff), .rd(rd));
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic go(input logic s);
    if (s) start_bit = 1'b1;
    else trig = 1'b1;
    @(negedge clk_sys);
    start_bit = 1'b0;
    trig = 1'b0;
  endtask : go
  task automatic gap();
    logic p;
    n = 0;
    do begin
      p = done_ff;
      @(negedge clk_sys);
      n++;
    end while (!(p === 1'b0 && done_ff === 1'b1) && n < 200);
  endtask : gap
  task automatic t_single();
    lat = 4'h6;
    go(1'b0);
    gap();
    `CHK("latency", 17, n)
    `CHK("result", 12'h010, result_ff)
    `CHK("status", 1'b1, status_ff)
    repeat (3) @(negedge clk_sys);
    `CHK("done held", 1'b1, done_ff)
    repeat (6) @(negedge clk_sys);
    `CHK("done clr", 1'b0, done_ff)
    `CHK("standby", 1'b0, busy_ff)
    lat = 4'h0;
  endtask : t_single
  task automatic t_lowres();
    lo_res = 1'b1;
    mod_bit = 1'b0;
    go(1'b1);
    repeat (3) @(negedge clk_sys);
    go(1'b0);
    gap();
    `CHK("short latency", 5, n)
    `CHK("zero result", 12'h000, result_ff)
    repeat (2) @(negedge clk_sys);
    `CHK("idle", 1'b0, busy_ff)
    lo_res = 1'b0;
    mod_bit = 1'b1;
  endtask : t_lowres
  task automatic t_cont();
    mode = 2'h1;
    go(1'b1);
    gap();
    `CHK("prime", 17, n)
    gap();
    `CHK("rate", 4, n)
    `CHK("cont result", 12'h010, result_ff)
    // single switch only, to see validity recover
    in_sel_chg = 1'b1;
    @(negedge clk_sys);
    in_sel_chg = 1'b0;
    for (int i = 0; i < 4; i++) begin
      gap();
      `CHK("valid", i == 3, valid_ff)
    end
    stop = 1'b1;
    repeat (6) @(negedge clk_sys);
    `CHK("stopped", 1'b0, busy_ff)
    stop = 1'b0;
  endtask : t_cont
  task automatic t_multi(input logic [1:0] m);
    mode = m;
    go(1'b0);
    gap();
    `CHK("multi first", 17, n)
    gap();
    `CHK("reprime", 16, n)
    stop = 1'b1;
    repeat (20) @(negedge clk_sys);
    `CHK("multi stop", 1'b0, busy_ff)
    stop = 1'b0;
  endtask : t_multi
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    t_single();
    t_lowres();
    t_cont();
    t_multi(2'h2);
    t_multi(2'h3);
    tally_and_finish();
  end
  initial begin
    #150000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb_sigma_delta_adc_conversion_sequencer
`default_nettype wire
